// *** rtl/wsg_cfg.svh ***
`ifndef WSG_CFG_SVH
`define WSG_CFG_SVH
// status word fields
`define WSG_ST_TRANS_BIT   23
`define WSG_ST_CACHE_LSB   24
// mode word fields
`define WSG_MD_RND_LSB     0
`define WSG_MD_SUB_LSB     4
`define WSG_MD_NAN_BIT     8
`define WSG_MD_IEEE_BIT    9
`define WSG_MD_LOD_BIT     10
`define WSG_MD_STEP_BIT    11
`define WSG_MD_EXC_LSB     12
`define WSG_MD_IDX_BIT     27
`define WSG_MD_SKIP_BIT    28
`define WSG_MD_CSP_LSB     29
`define WSG_MODE_RST       32'h0000_0000
`define WSG_DESC_RST       32'h0000_0000
// scalar register allocation
`define WSG_SG_MIN         8
`define WSG_SG_MAX         102
`define WSG_SG_UNIT        16
`define WSG_SG_TRAP        16
// local share blocks are 64 words = 256 bytes
`define WSG_LDS_BLK_SH     8
`define WSG_LDS_SIZE_W     17
`endif

// *** rtl/wsg_pkg.sv ***
package wsg_pkg;
  typedef struct packed {
    logic        instr_translated_space;
    logic [2:0]  cache_policy;
    logic        trap_present;
    logic [2:0]  sgpr_blocks;
    logic [8:0]  vgpr_size;
    logic [7:0]  lds_base_blk;
    logic [16:0] lds_size;
  } wsg_create_t;
  typedef struct packed {
    logic [1:0] round_sp;
    logic [1:0] round_dp;
    logic [1:0] subn_sp;
    logic [1:0] subn_dp;
    logic       nan_zero_clamp;
    logic       ieee_mode;
  } wsg_fp_ctl_t;
  typedef enum logic [2:0] {
    WSG_SCC_NONE,
    WSG_SCC_CMP,
    WSG_SCC_ARITH,
    WSG_SCC_LOGIC,
    WSG_SCC_MOVE
  } wsg_scc_op_t;
  typedef enum logic [1:0] {
    WSG_W1,
    WSG_W2,
    WSG_W4
  } wsg_width_t;
  typedef enum logic [1:0] {
    WSG_CL_SCALAR,
    WSG_CL_VECTOR,
    WSG_CL_END
  } wsg_class_t;
endpackage

// *** rtl/wsg_wave_state.sv ***
// Contract
// - status bit reports whether instructions live in translated address space
// - three-bit cache policy: vector L1, L2, scalar data cache
// - rounding field, low pair single, high pair double precision
// - subnormal field, low pair single, high pair double precision
// - nan clamp bit makes vector ALU replace NaN with zero
// - ieee bit quiets and propagates signaling NaN inputs
// - sticky detail-clamp flag set by texture clamps until software writes
// - single-step traps after every instruction except program end, if handler
// - seven exception enables trap only while a trap handler is present
// - vector-skip bit skips vector, memory, export and share instructions
// - branch stack pointer in top bits, index enable below skip bit
// - scalar source out of range reads register zero, destination writes nothing
// - vector source out of range uses register zero, bad destination is no-op
// - local-share address beyond min size: write dropped, read zero
// - memory reads check all returned registers including residency register
// - any out-of-range destination suppresses all results
// - 8 to 102 scalar registers in units of 16, top two alias mask
// - 16 trap registers after mask, writable only while privileged
// - 64-bit pairs even aligned, quad writes quad aligned
// - local share in aligned 64-word blocks, accesses confined
// - descriptor register serves as index and operand data
// - condition bit on compare, carry, nonzero logic; moves keep it
`include "wsg_cfg.svh"
module wsg_wave_state #(
  parameter int SG_DEPTH = 118
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_create,
  input  wire wsg_pkg::wsg_create_t  i_create_cfg,
  input  wire logic                  i_priv,
  input  wire logic                  i_mode_we,
  input  wire logic [31:0]           i_mode_wdata,
  input  wire logic                  i_desc_we,
  input  wire logic [31:0]           i_desc_wdata,
  input  wire logic                  i_tex_clamp,
  input  wire logic                  i_instr_done,
  input  wire wsg_pkg::wsg_class_t   i_instr_class,
  input  wire logic [6:0]            i_exc_flags,
  input  wire wsg_pkg::wsg_scc_op_t  i_scc_op,
  input  wire logic                  i_scc_val,
  input  wire logic [31:0]           i_alu_result,
  input  wire logic [7:0]            i_sg_ridx,
  input  wire logic                  i_sg_rindexed,
  input  wire logic                  i_sg_we,
  input  wire logic [7:0]            i_sg_widx,
  input  wire wsg_pkg::wsg_width_t   i_sg_wwidth,
  input  wire logic [127:0]          i_sg_wdata,
  input  wire logic                  i_vg_chk,
  input  wire logic [8:0]            i_vg_src,
  input  wire logic [8:0]            i_vg_dst,
  input  wire logic [2:0]            i_vg_dcnt,
  input  wire logic                  i_vg_prt,
  input  wire logic                  i_lds_req,
  input  wire logic                  i_lds_wr,
  input  wire logic [17:0]           i_lds_addr,
  output logic [31:0]                o_status,
  output logic [31:0]                o_mode,
  output logic [31:0]                o_desc,
  output wsg_pkg::wsg_fp_ctl_t       o_fp_ctl,
  output logic [6:0]                 o_exc_en,
  output logic                       o_scc,
  output logic                       o_trap_req,
  output logic                       o_skip,
  output logic [31:0]                o_sg_rdata,
  output logic                       o_sg_wdrop,
  output logic [63:0]                o_vcc,
  output logic [8:0]                 o_vg_src_eff,
  output logic                       o_vg_nop,
  output logic                       o_lds_wr_ok,
  output logic                       o_lds_rd_zero,
  output logic [17:0]                o_lds_phys
);
  import wsg_pkg::*;

  // refused at elaboration: indices are seven bits wide and must reach the trap area
  if (SG_DEPTH < `WSG_SG_MAX + `WSG_SG_TRAP || SG_DEPTH > 127) begin : g_depth_chk
    $error("SG_DEPTH cannot hold allocation plus trap area");
  end

  // ==========================================================
  // allocation size
  // ==========================================================
  function automatic logic [6:0] alloc_size(input logic [2:0] blocks);
    logic [9:0] n;
    n = 10'(blocks) * 10'(`WSG_SG_UNIT);
    if (n < 10'(`WSG_SG_MIN)) begin
      alloc_size = 7'(`WSG_SG_MIN);
    end else if (n > 10'(`WSG_SG_MAX)) begin
      alloc_size = 7'(`WSG_SG_MAX);
    end else begin
      alloc_size = n[6:0];
    end
  endfunction

  // ==========================================================
  // status, mode, descriptor
  // ==========================================================
  logic [31:0] status_reg;
  logic [31:0] mode_reg;
  logic [31:0] desc_reg;
  logic        trap_en_reg;
  logic [6:0]  sg_size_reg;
  logic [8:0]  vg_size_reg;
  logic [7:0]  lds_blk_reg;
  logic [16:0] lds_size_reg;
  logic        scc_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg   <= 32'h0000_0000;
      trap_en_reg  <= 1'b0;
      sg_size_reg  <= 7'(`WSG_SG_MIN);
      vg_size_reg  <= 9'h000;
      lds_blk_reg  <= 8'h00;
      lds_size_reg <= 17'h0_0000;
    end else if (i_create) begin
      status_reg <= 32'h0000_0000;
      status_reg[`WSG_ST_TRANS_BIT] <= i_create_cfg.instr_translated_space;
      status_reg[`WSG_ST_CACHE_LSB +: 3] <= i_create_cfg.cache_policy;
      trap_en_reg  <= i_create_cfg.trap_present;
      sg_size_reg  <= alloc_size(i_create_cfg.sgpr_blocks);
      vg_size_reg  <= i_create_cfg.vgpr_size;
      lds_blk_reg  <= i_create_cfg.lds_base_blk;
      lds_size_reg <= i_create_cfg.lds_size;
    end
  end

  // a texture clamp in the cycle of a software write still lands
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_reg <= `WSG_MODE_RST;
    end else begin
      if (i_mode_we) begin
        mode_reg <= i_mode_wdata;
      end
      if (i_tex_clamp) begin
        mode_reg[`WSG_MD_LOD_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      desc_reg <= `WSG_DESC_RST;
    end else if (i_desc_we) begin
      desc_reg <= i_desc_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scc_reg <= 1'b0;
    end else begin
      case (i_scc_op)
        WSG_SCC_CMP:   scc_reg <= i_scc_val;
        WSG_SCC_ARITH: scc_reg <= i_scc_val;
        WSG_SCC_LOGIC: scc_reg <= |i_alu_result;
        default:       scc_reg <= scc_reg;
      endcase
    end
  end

  assign o_status = status_reg;
  assign o_mode   = mode_reg;
  assign o_desc   = desc_reg;
  assign o_scc    = scc_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fp_ctl <= '0;
      o_exc_en <= 7'h00;
    end else begin
      o_fp_ctl.round_sp <= mode_reg[`WSG_MD_RND_LSB +: 2];
      o_fp_ctl.round_dp <= mode_reg[`WSG_MD_RND_LSB + 2 +: 2];
      o_fp_ctl.subn_sp  <= mode_reg[`WSG_MD_SUB_LSB +: 2];
      o_fp_ctl.subn_dp  <= mode_reg[`WSG_MD_SUB_LSB + 2 +: 2];
      o_fp_ctl.nan_zero_clamp <= mode_reg[`WSG_MD_NAN_BIT];
      o_fp_ctl.ieee_mode <= mode_reg[`WSG_MD_IEEE_BIT];
      o_exc_en <= mode_reg[`WSG_MD_EXC_LSB +: 7];
    end
  end

  // ==========================================================
  // trap and skip
  // ==========================================================
  logic step_hit;
  logic exc_hit;
  assign step_hit = i_instr_done && mode_reg[`WSG_MD_STEP_BIT] && i_instr_class != WSG_CL_END;
  assign exc_hit  = |(i_exc_flags & mode_reg[`WSG_MD_EXC_LSB +: 7]);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_trap_req <= 1'b0;
      o_skip     <= 1'b0;
    end else begin
      o_trap_req <= trap_en_reg && (step_hit || exc_hit);
      // skip registered, flagged the cycle after completion, never issued downstream
      o_skip <= i_instr_done && i_instr_class == WSG_CL_VECTOR
                && mode_reg[`WSG_MD_SKIP_BIT];
    end
  end

  // ==========================================================
  // scalar register file
  // ==========================================================
  logic [31:0] sg_mem [SG_DEPTH];
  logic [7:0]  rd_idx;
  logic        rd_ok;
  logic [2:0]  wn;
  logic        wr_ok;
  logic        wr_align;

  // trap area sits right after the allocation while a handler is present; reads at any privilege, writes only privileged
  function automatic logic sg_ok(input logic [7:0] idx, input logic is_wr);
    logic [7:0] lim;
    lim = {1'b0, sg_size_reg};
    if (trap_en_reg && (!is_wr || i_priv)) begin
      lim = lim + 8'(`WSG_SG_TRAP);
    end
    sg_ok = !idx[7] && idx < lim;
  endfunction

  // index mode adds the descriptor's low byte as a signed eight-bit offset
  assign rd_idx = (i_sg_rindexed && mode_reg[`WSG_MD_IDX_BIT])
                  ? i_sg_ridx + desc_reg[7:0] : i_sg_ridx;
  assign rd_ok  = sg_ok(rd_idx, 1'b0);
  assign wn     = (i_sg_wwidth == WSG_W4) ? 3'd4 : (i_sg_wwidth == WSG_W2) ? 3'd2 : 3'd1;
  assign wr_align = (i_sg_wwidth == WSG_W1)
                 || (i_sg_wwidth == WSG_W2 && !i_sg_widx[0])
                 || (i_sg_wwidth == WSG_W4 && i_sg_widx[1:0] == 2'b00);
  // the last word of the group decides for the whole group
  assign wr_ok = sg_ok(i_sg_widx, 1'b1) && sg_ok(i_sg_widx + 8'(wn) - 8'd1, 1'b1)
                 && !i_sg_widx[7] && wr_align;

  always_ff @(posedge i_clk) begin
    if (i_sg_we && wr_ok) begin
      for (int k = 0; k < 4; k++) begin
        if (k < int'(wn)) begin
          sg_mem[7'(i_sg_widx) + 7'(k)] <= i_sg_wdata[32*k +: 32];
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sg_rdata <= 32'h0000_0000;
      o_sg_wdrop <= 1'b0;
      o_vcc      <= 64'h0;
    end else begin
      o_sg_rdata <= rd_ok ? sg_mem[rd_idx[6:0]] : sg_mem[0];
      o_sg_wdrop <= i_sg_we && !wr_ok;
      o_vcc <= {sg_mem[sg_size_reg - 7'd1], sg_mem[sg_size_reg - 7'd2]};
    end
  end

  // ==========================================================
  // vector register and local share checks
  // ==========================================================
  logic [9:0]  vg_last;
  logic        vg_src_ok;
  logic        vg_dst_ok;
  logic [16:0] lds_lim;
  logic        lds_ok;

  assign vg_src_ok = !i_vg_src[8] && i_vg_src < vg_size_reg;
  assign vg_last   = {1'b0, i_vg_dst} + 10'(i_vg_dcnt) + 10'(i_vg_prt) - 10'd1;
  assign vg_dst_ok = !i_vg_dst[8] && i_vg_dst < vg_size_reg
                     && vg_last < {1'b0, vg_size_reg};
  assign lds_lim   = (desc_reg[16:0] < lds_size_reg) ? desc_reg[16:0] : lds_size_reg;
  assign lds_ok    = !i_lds_addr[17] && i_lds_addr[16:0] < lds_lim;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_vg_src_eff <= 9'h000;
      o_vg_nop     <= 1'b0;
    end else if (i_vg_chk) begin
      o_vg_src_eff <= vg_src_ok ? i_vg_src : 9'h000;
      o_vg_nop     <= !vg_dst_ok;
    end else begin
      o_vg_nop <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_lds_wr_ok   <= 1'b0;
      o_lds_rd_zero <= 1'b0;
      o_lds_phys    <= 18'h0_0000;
    end else begin
      o_lds_wr_ok   <= i_lds_req && i_lds_wr && lds_ok;
      o_lds_rd_zero <= i_lds_req && !i_lds_wr && !lds_ok;
      // base on block boundary; clamp keeps the sum inside the allocation
      o_lds_phys <= ({10'h000, lds_blk_reg} << `WSG_LDS_BLK_SH)
                    + (lds_ok ? i_lds_addr : 18'h0_0000);
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  a_lod_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_tex_clamp |=> o_mode[`WSG_MD_LOD_BIT])
    else $error("clamp flag not set");
  a_lod_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_mode[`WSG_MD_LOD_BIT] && !i_mode_we |=> o_mode[`WSG_MD_LOD_BIT])
    else $error("clamp flag lost");
  a_trap_gate: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !trap_en_reg |=> !o_trap_req)
    else $error("trap without handler");
  a_step_end: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_instr_class == WSG_CL_END && i_exc_flags == 7'h00 |=> !o_trap_req)
    else $error("step trap after end");
  a_step_trap: assert property (@(posedge i_clk) disable iff (!i_resetn)
    trap_en_reg && step_hit |=> o_trap_req)
    else $error("step trap missing");
  a_skip_vec: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_skip |-> $past(mode_reg[`WSG_MD_SKIP_BIT]) && $past(i_instr_class) == WSG_CL_VECTOR)
    else $error("skip without bit");
  a_scc_move: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_scc_op == WSG_SCC_MOVE |=> $stable(o_scc))
    else $error("move changed condition bit");
  a_sg_oor: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !rd_ok ##1 1'b1 |-> o_sg_rdata == $past(sg_mem[0]))
    else $error("bad read not register zero");
  a_sg_neg: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_sg_we && i_sg_widx[7] |=> o_sg_wdrop)
    else $error("negative scalar write kept");
  a_lds_drop: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_lds_req && i_lds_wr && i_lds_addr[16:0] >= lds_lim |=> !o_lds_wr_ok)
    else $error("out of range share write kept");
  a_lds_neg: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_lds_req && !i_lds_wr && i_lds_addr[17] |=> o_lds_rd_zero)
    else $error("negative share read not zero");
  a_vg_src: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_vg_chk && i_vg_src >= vg_size_reg |=> o_vg_src_eff == 9'h000)
    else $error("bad vector source not zero");
  // the residency register sits right after the last returned register
  a_vg_prt: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_vg_chk && i_vg_prt && {1'b0, i_vg_dst} + 10'(i_vg_dcnt) >= {1'b0, vg_size_reg}
    |=> o_vg_nop)
    else $error("residency register out of range kept");
  a_misalign: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_sg_we && i_sg_wwidth == WSG_W2 && i_sg_widx[0] |=> o_sg_wdrop)
    else $error("odd pair write kept");
endmodule // wsg_wave_state

// *** verification/wsg_wave_state_tb.sv ***
module wsg_wave_state_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wsg_pkg::*;

  // ==========================================================
  // compare helper
  `define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp); \
    end \
  end

  logic        i_clk, i_resetn, i_create, i_priv, i_mode_we, i_desc_we, i_tex_clamp;
  logic        i_instr_done, i_scc_val, i_sg_rindexed, i_sg_we, i_vg_chk, i_vg_prt;
  logic        i_lds_req, i_lds_wr;
  wsg_create_t i_create_cfg;
  wsg_class_t  i_instr_class;
  wsg_scc_op_t i_scc_op;
  wsg_width_t  i_sg_wwidth;
  logic [31:0] i_mode_wdata, i_desc_wdata, i_alu_result;
  logic [6:0]  i_exc_flags;
  logic [7:0]  i_sg_ridx, i_sg_widx;
  logic [127:0] i_sg_wdata;
  logic [8:0]  i_vg_src, i_vg_dst;
  logic [2:0]  i_vg_dcnt;
  logic [17:0] i_lds_addr, o_lds_phys;
  logic [31:0] o_status, o_mode, o_desc, o_sg_rdata;
  wsg_fp_ctl_t o_fp_ctl;
  logic [6:0]  o_exc_en;
  logic        o_scc, o_trap_req, o_skip, o_sg_wdrop, o_vg_nop, o_lds_wr_ok, o_lds_rd_zero;
  logic [63:0] o_vcc;
  logic [8:0]  o_vg_src_eff;
  int          n_errors, check_count, cyc;
  logic [31:0] v;

  wsg_wave_state wsg_wave_state_inst (.*);

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      close_out();
    end
  end

  // ==========================================================
  // drivers: requests raised at one edge, dropped at the next
  task automatic fin();
    @(posedge i_clk);
    {i_create, i_mode_we, i_desc_we, i_tex_clamp, i_instr_done} <= '0;
    {i_sg_we, i_vg_chk, i_lds_req} <= '0;
    i_exc_flags <= '0;
    i_scc_op    <= WSG_SCC_NONE;
    #1;
  endtask

  task automatic mk(logic tr, logic [2:0] cp, logic tp, logic [2:0] sb, logic [8:0] vs,
                    logic [7:0] lb, logic [16:0] ls);
    @(posedge i_clk);
    i_create     <= 1'b1;
    i_create_cfg <= '{tr, cp, tp, sb, vs, lb, ls};
    fin();
  endtask

  task automatic wm(logic [31:0] d, logic clamp);
    @(posedge i_clk);
    i_mode_we    <= 1'b1;
    i_mode_wdata <= d;
    i_tex_clamp  <= clamp;
    fin();
    fin();
  endtask

  task automatic wd(logic [31:0] d);
    @(posedge i_clk);
    i_desc_we    <= 1'b1;
    i_desc_wdata <= d;
    fin();
  endtask

  task automatic ins(wsg_class_t c, logic [6:0] f, logic t, logic s);
    @(posedge i_clk);
    i_instr_done  <= 1'b1;
    i_instr_class <= c;
    i_exc_flags   <= f;
    fin();
    `CHK(o_trap_req, t)
    `CHK(o_skip, s)
  endtask

  task automatic sc(wsg_scc_op_t op, logic val, logic [31:0] alu, logic e);
    @(posedge i_clk);
    i_scc_op     <= op;
    i_scc_val    <= val;
    i_alu_result <= alu;
    fin();
    `CHK(o_scc, e)
  endtask

  task automatic wr(logic [7:0] idx, wsg_width_t w, logic [127:0] d, logic drop);
    @(posedge i_clk);
    i_sg_we     <= 1'b1;
    i_sg_widx   <= idx;
    i_sg_wwidth <= w;
    i_sg_wdata  <= d;
    fin();
    `CHK(o_sg_wdrop, drop)
  endtask

  task automatic rd(logic [7:0] idx, logic ix, logic [31:0] e);
    @(posedge i_clk);
    i_sg_ridx     <= idx;
    i_sg_rindexed <= ix;
    fin();
    `CHK(o_sg_rdata, e)
  endtask

  task automatic vc(logic [8:0] s, logic [8:0] d, logic [2:0] n, logic p, logic [8:0] es,
                    logic en);
    @(posedge i_clk);
    {i_vg_chk, i_vg_src, i_vg_dst, i_vg_dcnt, i_vg_prt} <= {1'b1, s, d, n, p};
    fin();
    `CHK(o_vg_src_eff, es)
    `CHK(o_vg_nop, en)
  endtask

  task automatic ld(logic w, logic [17:0] a, logic bad);
    @(posedge i_clk);
    {i_lds_req, i_lds_wr, i_lds_addr} <= {1'b1, w, a};
    fin();
    if (w) `CHK(o_lds_wr_ok, !bad)
    else `CHK(o_lds_rd_zero, bad)
    if (!bad) `CHK(o_lds_phys, 18'(a + 18'h300))
  endtask

  function automatic logic [31:0] exp_status(logic tr, logic [2:0] cp);
    return {5'h0, cp, tr, 23'h0};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    {i_resetn, i_create, i_priv, i_mode_we, i_desc_we, i_tex_clamp} = '0;
    {i_instr_done, i_scc_val, i_sg_rindexed, i_sg_we, i_vg_chk, i_vg_prt} = '0;
    {i_lds_req, i_lds_wr, i_exc_flags, i_sg_ridx, i_sg_widx, i_sg_wdata} = '0;
    {i_mode_wdata, i_desc_wdata, i_alu_result, i_vg_src, i_vg_dst, i_vg_dcnt, i_lds_addr} = '0;
    i_create_cfg  = '0;
    i_instr_class = WSG_CL_SCALAR;
    i_scc_op      = WSG_SCC_NONE;
    i_sg_wwidth   = WSG_W1;
    v = $urandom(32'h32FB);
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    fin();
    `CHK(o_mode, 32'h0)
    for (int k = 0; k < 6; k++) begin
      v = $urandom;
      mk(v[0], v[3:1], v[4], v[7:5], v[16:8], 8'h0, 17'h0);
      `CHK(o_status, exp_status(v[0], v[3:1]))
    end
    $display("test status done");
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      v[10] = 1'b0;
      wm(v, 1'b0);
      `CHK(o_mode, v)
      `CHK({o_fp_ctl.round_dp, o_fp_ctl.round_sp}, v[3:0])
      `CHK({o_fp_ctl.subn_dp, o_fp_ctl.subn_sp}, v[7:4])
      `CHK(o_fp_ctl.nan_zero_clamp, v[8])
      `CHK(o_fp_ctl.ieee_mode, v[9])
      `CHK(o_exc_en, v[18:12])
    end
    wm(32'h0, 1'b0);
    @(posedge i_clk);
    i_tex_clamp <= 1'b1;
    fin();
    fin();
    `CHK(o_mode[10], 1'b1)
    wm(32'h0, 1'b1);
    `CHK(o_mode[10], 1'b1)
    wm(32'h0, 1'b0);
    `CHK(o_mode[10], 1'b0)
    $display("test mode done");
    // trap handler present, small allocations for the range checks below
    mk(1'b0, 3'h0, 1'b1, 3'h2, 9'd64, 8'h3, 17'd256);
    wm(32'h800, 1'b0);
    ins(WSG_CL_SCALAR, 7'h0, 1'b1, 1'b0);
    ins(WSG_CL_END, 7'h0, 1'b0, 1'b0);
    for (int k = 0; k < 7; k++) begin
      wm(32'h1000 << k, 1'b0);
      ins(WSG_CL_VECTOR, 7'h1 << k, 1'b1, 1'b0);
      ins(WSG_CL_VECTOR, 7'h7F ^ (7'h1 << k), 1'b0, 1'b0);
    end
    wm(32'h1000_0000, 1'b0);
    ins(WSG_CL_VECTOR, 7'h0, 1'b0, 1'b1);
    ins(WSG_CL_SCALAR, 7'h0, 1'b0, 1'b0);
    $display("test trap done");
    sc(WSG_SCC_CMP, 1'b1, 32'h0, 1'b1);
    sc(WSG_SCC_MOVE, 1'b0, 32'h0, 1'b1);
    sc(WSG_SCC_ARITH, 1'b0, 32'h5, 1'b0);
    sc(WSG_SCC_LOGIC, 1'b0, 32'h8000_0000, 1'b1);
    sc(WSG_SCC_LOGIC, 1'b1, 32'h0, 1'b0);
    $display("test cond done");
    // 32 user registers, trap area 32..47
    wr(8'd0, WSG_W1, 128'hA5A5, 1'b0);
    wr(8'd3, WSG_W1, 128'h1234, 1'b0);
    rd(8'd3, 1'b0, 32'h1234);
    rd(8'd200, 1'b0, 32'hA5A5);
    rd(8'd50, 1'b0, 32'hA5A5);
    wr(8'd50, WSG_W1, 128'h77, 1'b1);
    wr(8'd200, WSG_W1, 128'h77, 1'b1);
    rd(8'd0, 1'b0, 32'hA5A5);
    wr(8'd40, WSG_W1, 128'h99, 1'b1);
    i_priv <= 1'b1;
    wr(8'd40, WSG_W1, 128'h99, 1'b0);
    i_priv <= 1'b0;
    rd(8'd40, 1'b0, 32'h99);
    wr(8'd5, WSG_W2, 128'h1, 1'b1);
    wr(8'd6, WSG_W4, 128'h1, 1'b1);
    wr(8'd8, WSG_W4, {32'h44, 32'h33, 32'h22, 32'h11}, 1'b0);
    rd(8'd11, 1'b0, 32'h44);
    wr(8'd30, WSG_W2, {64'h0, 32'hBEEF, 32'hCAFE}, 1'b0);
    fin();
    `CHK(o_vcc, {32'hBEEF, 32'hCAFE})
    wr(8'd46, WSG_W4, 128'h1, 1'b1);
    wm(32'h0800_0000, 1'b0);
    wd(32'h5);
    `CHK(o_desc, 32'h5)
    rd(8'd5, 1'b1, 32'h33);
    // largest allocation is capped at 102
    mk(1'b0, 3'h0, 1'b0, 3'h7, 9'd64, 8'h3, 17'd256);
    wr(8'd100, WSG_W2, {64'h0, 32'hD00D, 32'hF00D}, 1'b0);
    fin();
    `CHK(o_vcc, {32'hD00D, 32'hF00D})
    wr(8'd102, WSG_W1, 128'h1, 1'b1);
    // aligned quad whose last two words fall past the allocation: nothing lands
    wr(8'd100, WSG_W4, 128'h1, 1'b1);
    rd(8'd100, 1'b0, 32'hF00D);
    $display("test scalar done");
    vc(9'd10, 9'd0, 3'd1, 1'b0, 9'd10, 1'b0);
    vc(9'd70, 9'd0, 3'd1, 1'b0, 9'd0, 1'b0);
    vc(9'd1, 9'd64, 3'd1, 1'b0, 9'd1, 1'b1);
    vc(9'd1, 9'd60, 3'd4, 1'b0, 9'd1, 1'b0);
    vc(9'd1, 9'd60, 3'd4, 1'b1, 9'd1, 1'b1);
    $display("test vector done");
    wd(32'd100);
    ld(1'b0, 18'd99, 1'b0);
    ld(1'b1, 18'd100, 1'b1);
    ld(1'b1, 18'd99, 1'b0);
    ld(1'b0, 18'h20000, 1'b1);
    wd(32'd1000);
    ld(1'b1, 18'd255, 1'b0);
    ld(1'b0, 18'd256, 1'b1);
    $display("test share done");
    close_out();
  end
endmodule // wsg_wave_state_tb
